// >>> bench/dwss_host_model.sv
// dwss_host_model: two-wire bus master, bit-banged on mclk falls.
// assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
`default_nettype none

module dwss_host_model (
    input wire logic i_mclk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    // ----------------------------------------------------------------
    // bus phases; scl stands high between frames
    // ----------------------------------------------------------------
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic q();
        repeat (2) @(negedge i_mclk);
    endtask : q
    task automatic bit_io(input logic b, output logic r);
        o_sda_oe = !b; // pull low only
        q();
        o_scl = 1'b1; // host times every bit
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
        q();
    endtask : bit_io
    task automatic start();
        // extra wait lets a device ack drop before a repeated start
        o_sda_oe = 1'b0;
        q();
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe = 1'b1;
        q();
        o_scl = 1'b0;
        q();
    endtask : start
    task automatic stop();
        o_sda_oe = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe = 1'b0;
        q();
        q();
    endtask : stop
    task automatic send(input logic [7:0] b, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, a);
    endtask : send
    task automatic recv(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(nack, r);
    endtask : recv
endmodule : dwss_host_model

`default_nettype wire

// >>> bench/dwss_sva.sv
// dwss_sva: port-level assertions for dwss_top.
// assumes scl half periods of at least 4 mclk cycles.
`timescale 1ns/10ps
`default_nettype none

module dwss_sva
    import dwss_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda_in,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [3:0] i_device_select_inputs,
    input wire logic [NUM_CH-1:0][TAP_CNT-1:0] o_tap_select
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // saturating count of scl-high cycles; long highs mean no bus edge
    logic [3:0] hi_cnt;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hi_cnt <= 4'h0;
        end else if (!i_scl) begin
            hi_cnt <= 4'h0;
        end else if (hi_cnt != 4'hF) begin
            hi_cnt <= hi_cnt + 4'h1;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    sequence s_scl_settled;
        i_scl ##3 i_scl;
    endsequence
    sequence s_drive_on;
        !o_sda_oe ##1 o_sda_oe;
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_sda_low_only: assert property (o_sda_out == 1'b0)
        else $error("data line driven high");
    a_tap_hot_ch0: assert property ($onehot(o_tap_select[0]))
        else $error("channel 0 taps not one-hot");
    a_tap_hot_ch1: assert property ($onehot(o_tap_select[1]))
        else $error("channel 1 taps not one-hot");
    a_power_up_recall: assert property ($rose(i_reset_n) |->
        ##[1:2] (o_tap_select[0][SLOT_INIT] && o_tap_select[1][SLOT_INIT]))
        else $error("wipers did not recall slot 0");
    a_oe_quiet_idle: assert property ((hi_cnt > 4'h6) |->
        $stable(o_sda_oe)) else $error("data drive moved without scl");
    a_tap_quiet_idle: assert property ((hi_cnt > 4'h8) |->
        $stable(o_tap_select)) else $error("tap moved without scl");
    a_oe_stable_high: assert property (s_scl_settled |->
        $stable(o_sda_oe)) else $error("data drive moved with scl high");
    a_ack_after_fall: assert property ($rose(o_sda_oe) |->
        !$past(i_scl, 2)) else $error("drive began outside scl low");
    a_ack_min_hold: assert property (s_drive_on |->
        o_sda_oe [*4]) else $error("drive released too early");
    a_wire_pulled_low: assert property (o_sda_oe |-> !i_sda_in)
        else $error("data wire not low while driven");
endmodule : dwss_sva

bind dwss_top dwss_sva u_sva (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_scl(i_scl),
    .i_sda_in(i_sda_in),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .i_device_select_inputs(i_device_select_inputs),
    .o_tap_select(o_tap_select)
);

`default_nettype wire

// >>> bench/tb_dual_wiper_setting_store.sv
// tb_dual_wiper_setting_store: self-checking bench for dwss_top.
// assumes the host model and a pulled-up data wire.
`timescale 1ns/10ps
`default_nettype none

module tb_dual_wiper_setting_store;
    import dwss_pkg::*;
    logic clk, rst_n, scl, host_oe, dut_oe, dut_out, sda, ack;
    logic [3:0] sel;
    logic [7:0] rd;
    logic [NUM_CH-1:0][TAP_CNT-1:0] taps;
    int mismatches, n_checks;
    assign sda = !(dut_oe || host_oe);
    dwss_top dut (.i_mclk(clk), .i_reset_n(rst_n), .i_scl(scl),
        .i_sda_in(sda), .o_sda_out(dut_out), .o_sda_oe(dut_oe),
        .i_device_select_inputs(sel), .o_tap_select(taps));
    dwss_host_model host (.i_mclk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe(host_oe));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] ins(input logic [3:0] op,
                                       input logic [1:0] s, input logic c);
        ins = {op, s, 1'b0, c};
    endfunction : ins
    task automatic tap(input int ch, input logic [5:0] v);
        chk("tap", 64'h1 << v, taps[ch]);
    endtask : tap
    task automatic put(input logic [7:0] b);
        host.send(b, ack);
        chk("ack", 64'h0, {63'h0, ack});
    endtask : put
    task automatic cmd(input logic [7:0] i, input logic [7:0] d,
                       input bit has_d);
        host.start();
        put({ADDR_TYPE, sel, 1'b0});
        put(i);
        if (has_d) begin
            put(d);
        end
        host.stop();
    endtask : cmd
    task automatic rd_back(input logic [7:0] i, input logic [5:0] v);
        host.start();
        put({ADDR_TYPE, sel, 1'b0});
        put(i);
        host.start();
        put({ADDR_TYPE, sel, 1'b1});
        host.recv(1'b1, rd);
        host.stop();
        chk("read", {58'h0, v}, {56'h0, rd});
    endtask : rd_back
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : do_reset
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_recall();
        tap(0, SLOT_INIT);
        tap(1, SLOT_INIT);
        rd_back(ins(OP_RD_SLOT, 2'h0, 1'b1), SLOT_INIT);
    endtask : t_recall
    task automatic t_wiper();
        cmd(ins(OP_WR_WIPER, 2'h0, 1'b0), 8'hD5, 1'b1);
        cmd(ins(OP_WR_WIPER, 2'h0, 1'b1), 8'h3F, 1'b1);
        tap(0, 6'h15);
        tap(1, 6'h3F);
        rd_back(ins(OP_RD_WIPER, 2'h0, 1'b1), 6'h3F);
        rd_back(ins(OP_RD_WIPER, 2'h0, 1'b0), 6'h15);
        host.start();
        put({ADDR_TYPE, sel, 1'b0});
        put(ins(OP_RD_WIPER, 2'h0, 1'b1));
        host.start();
        put({ADDR_TYPE, sel, 1'b1});
        host.recv(1'b0, rd);
        chk("read1", 64'h3F, {56'h0, rd});
        host.recv(1'b1, rd);
        chk("read2", 64'h3F, {56'h0, rd});
        host.stop();
    endtask : t_wiper
    task automatic t_slots();
        for (int s = 0; s < 4; s++) begin
            cmd(ins(OP_WR_SLOT, 2'(s), 1'b0), 8'(s + 4), 1'b1);
            rd_back(ins(OP_RD_SLOT, 2'(s), 1'b0), 6'(s + 4));
        end
        tap(0, 6'h15);
        cmd(ins(OP_SLOT_TO_WIPER, 2'h2, 1'b0), 8'h00, 1'b0);
        tap(0, 6'h06);
        cmd(ins(OP_WIPER_TO_SLOT, 2'h3, 1'b1), 8'h00, 1'b0);
        rd_back(ins(OP_RD_SLOT, 2'h3, 1'b1), 6'h3F);
        rd_back(ins(OP_RD_SLOT, 2'h3, 1'b0), 6'h07);
    endtask : t_slots
    task automatic t_step();
        cmd(ins(OP_WR_WIPER, 2'h0, 1'b1), 8'h3E, 1'b1);
        cmd(ins(OP_WR_WIPER, 2'h0, 1'b0), 8'h01, 1'b1);
        for (int k = 0; k < 2; k++) begin
            cmd(ins(OP_INCDEC, 2'h0, 1'b1), 8'h01, 1'b1);
            tap(1, TAP_MAX);
            cmd(ins(OP_INCDEC, 2'h0, 1'b0), 8'h00, 1'b1);
            tap(0, TAP_MIN);
        end
    endtask : t_step
    task automatic t_select();
        host.start();
        host.send({ADDR_TYPE, ~sel, 1'b0}, ack);
        chk("nack", 64'h1, {63'h0, ack});
        host.send(ins(OP_WR_WIPER, 2'h0, 1'b0), ack);
        host.send(8'h11, ack);
        host.stop();
        tap(0, TAP_MIN);
        for (int k = 0; k < 16; k++) begin
            sel = 4'(k);
            repeat (4) @(negedge clk);
            cmd(ins(OP_WR_WIPER, 2'h0, 1'b0), 8'(k), 1'b1);
            tap(0, 6'(k));
        end
    endtask : t_select
    // ----------------------------------------------------------------
    // run
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #1_000_000;
        mismatches++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        sel = 4'hA;
        mismatches = 0;
        n_checks = 0;
        do_reset();
        t_recall();
        t_wiper();
        t_slots();
        t_step();
        t_select();
        do_reset();
        t_recall();
        wrap_up();
    end
endmodule : tb_dual_wiper_setting_store

`default_nettype wire

// >>> core/dwss_pkg.sv
// dual wiper setting store: shared constants, types and encodings.
// assumes a single 40 MHz clock domain with the serial bus sampled.

package dwss_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_CH = 2;
    localparam int NUM_SLOTS = 4;
    localparam int WIPER_W = 6;
    localparam int TAP_CNT = 64;
    localparam int SLOT_IDX_W = 3;
    localparam logic [5:0] TAP_MAX = 6'h3F;
    localparam logic [5:0] TAP_MIN = 6'h00;
    localparam logic [5:0] WIPER_RESET = 6'h00;
    // contents of a never-written slot; nonvolatile content is not modelled
    localparam logic [5:0] SLOT_INIT = 6'h20;

    // ----------------------------------------------------------------
    // serial address byte: type code, four select bits, direction bit
    // ----------------------------------------------------------------
    // type code value is arbitrary
    localparam logic [2:0] ADDR_TYPE = 3'h2;
    localparam int ADDR_TYPE_MSB = 7;
    localparam int ADDR_TYPE_LSB = 5;
    localparam int ADDR_SEL_MSB = 4;
    localparam int ADDR_SEL_LSB = 1;
    localparam int ADDR_RW_BIT = 0;

    // ----------------------------------------------------------------
    // instruction opcodes (upper nibble of the instruction byte)
    // ----------------------------------------------------------------
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_SLOT = 4'hB;
    localparam logic [3:0] OP_WR_SLOT = 4'hC;
    localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_WIPER_TO_SLOT = 4'hE;
    localparam logic [3:0] OP_INCDEC = 4'h2;
    localparam int STEP_UP_BIT = 0;

    typedef struct packed {
        logic [3:0] op;
        logic [1:0] slot;
        logic rsvd;
        logic ch;
    } dwss_instr_t;

    // ----------------------------------------------------------------
    // byte engine states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_RACK = 5'h10
    } dwss_state_t;

    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_INSTR = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;

endpackage : dwss_pkg

// >>> core/dwss_sync.sv
// dwss_sync: two flip-flop synchroniser for a bundle of pin levels.
// assumes every bit is an independent level from outside the clock.
`timescale 1ns/10ps
`default_nettype none

module dwss_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    // first stage is read by the second stage only
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta <= '1;
            o_sync <= '1;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end

endmodule : dwss_sync

`default_nettype wire

// >>> core/dwss_tap_decode.sv
// dwss_tap_decode: one channel's wiper value to a one-hot tap switch set.
// assumes the wiper value is already a register on the same clock.
`timescale 1ns/10ps
`default_nettype none

module dwss_tap_decode
    import dwss_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [WIPER_W-1:0] i_wiper,
    output logic [TAP_CNT-1:0] o_tap_select
);

    // registered so that no two switches close during a decode glitch
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tap_select <= 64'h0000_0000_0000_0001;
        end else begin
            o_tap_select <= 64'h0000_0000_0000_0001 << i_wiper;
        end
    end

endmodule : dwss_tap_decode

`default_nettype wire

// >>> core/dwss_top.sv
// dwss_top: dual wiper setting store with its two-wire serial slave.
// assumes the serial clock is far slower than i_mclk (at least 8 samples
// per serial period) and that an external pull-up holds the data line.
`timescale 1ns/10ps
`default_nettype none

module dwss_top
    import dwss_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic [3:0] i_device_select_inputs,
    output logic [NUM_CH-1:0][TAP_CNT-1:0] o_tap_select
);

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    logic [5:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [3:0] sel_s;
    logic scl_d;
    logic sda_d;

    // select pins share the synchroniser so all six see equal latency
    dwss_sync #(
        .WIDTH(6)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_async({i_device_select_inputs, i_sda_in, i_scl}),
        .o_sync(pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign sel_s = pins_s[5:2];

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ----------------------------------------------------------------
    // bus events, derived from the sampled serial clock and data pins
    // ----------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [NUM_CH-1:0][WIPER_W-1:0] wiper;
    logic [NUM_CH*NUM_SLOTS-1:0][WIPER_W-1:0] slot;
    logic recall_pending;
    logic incdec_mode;
    dwss_instr_t instr;
    dwss_instr_t rx_instr;
    logic [SLOT_IDX_W-1:0] rx_slot_idx;
    logic [SLOT_IDX_W-1:0] cur_slot_idx;

    // ----------------------------------------------------------------
    // byte engine registers
    // ----------------------------------------------------------------
    dwss_state_t state;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [2:0] bit_cnt;
    logic got8;
    logic [1:0] byte_idx;
    logic rd_dir;
    logic host_ack;
    logic addr_match;
    logic byte_done;
    logic [WIPER_W-1:0] read_val;
    logic next_sda_oe;

    // ----------------------------------------------------------------
    // address compare
    // ----------------------------------------------------------------
    // select pins are compared live; a change in mid-frame is not guarded
    assign addr_match =
        (rx_shift[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == ADDR_TYPE) &&
        (rx_shift[ADDR_SEL_MSB:ADDR_SEL_LSB] == sel_s);

    assign byte_done = (state == ST_RX) && scl_fall && got8;
    assign rx_instr = dwss_instr_t'(rx_shift);
    assign rx_slot_idx = {rx_instr.ch, rx_instr.slot};
    assign cur_slot_idx = {instr.ch, instr.slot};

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    // value returned on a read, chosen by the last instruction
    always_comb begin
        if (instr.op == OP_RD_SLOT) begin
            read_val = slot[cur_slot_idx];
        end else begin
            read_val = wiper[instr.ch];
        end
    end

    // ----------------------------------------------------------------
    // serial byte engine
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            bit_cnt <= 3'h0;
            got8 <= 1'b0;
            byte_idx <= BYTE_ADDR;
            rd_dir <= 1'b0;
            host_ack <= 1'b0;
        end else if (start_det) begin
            // a repeated start restarts addressing at any point
            state <= ST_RX;
            bit_cnt <= 3'h0;
            got8 <= 1'b0;
            byte_idx <= BYTE_ADDR;
        end else if (stop_det) begin
            state <= ST_IDLE;
            got8 <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    bit_cnt <= 3'h0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        rx_shift <= {rx_shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            got8 <= 1'b1;
                        end
                    end else if (byte_done) begin
                        got8 <= 1'b0;
                        if (byte_idx != BYTE_ADDR) begin
                            state <= ST_ACK;
                        end else if (addr_match) begin
                            state <= ST_ACK;
                            rd_dir <= rx_shift[ADDR_RW_BIT];
                        end else begin
                            // not ours: stay silent until the next start
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 3'h0;
                        if (rd_dir) begin
                            state <= ST_TX;
                            tx_shift <= {2'h0, read_val};
                        end else begin
                            state <= ST_RX;
                            if (byte_idx != BYTE_DATA) begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        tx_shift <= {tx_shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            state <= ST_RACK;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        host_ack <= ~sda_s;
                    end else if (scl_fall) begin
                        bit_cnt <= 3'h0;
                        if (host_ack) begin
                            state <= ST_TX;
                            tx_shift <= {2'h0, read_val};
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // data line: pull low or release, never drive high
    // ----------------------------------------------------------------
    always_comb begin
        case (state)
            ST_ACK: next_sda_oe = 1'b1;
            // the high level comes only from the external pull-up
            ST_TX: next_sda_oe = ~tx_shift[7];
            default: next_sda_oe = 1'b0;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
        end else begin
            o_sda_oe <= next_sda_oe;
            o_sda_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // wipers, slots and instruction execution
    // ----------------------------------------------------------------
    // slots are flip-flops: a real nonvolatile array and its write time
    // are outside this block, so contents return to SLOT_INIT on reset
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                wiper[c] <= WIPER_RESET;
            end
            for (int s = 0; s < NUM_CH * NUM_SLOTS; s++) begin
                slot[s] <= SLOT_INIT;
            end
            recall_pending <= 1'b1;
            incdec_mode <= 1'b0;
            instr <= '0;
        end else if (recall_pending) begin
            // first edge after release loads every wiper from its slot 0
            for (int c = 0; c < NUM_CH; c++) begin
                wiper[c] <= slot[c * NUM_SLOTS];
            end
            recall_pending <= 1'b0;
        end else if (start_det) begin
            // a new frame must repeat the mode instruction to keep stepping
            incdec_mode <= 1'b0;
        end else if (byte_done && byte_idx == BYTE_INSTR) begin
            instr <= rx_instr;
            incdec_mode <= (rx_instr.op == OP_INCDEC);
            if (rx_instr.op == OP_SLOT_TO_WIPER) begin
                wiper[rx_instr.ch] <= slot[rx_slot_idx];
            end else if (rx_instr.op == OP_WIPER_TO_SLOT) begin
                slot[rx_slot_idx] <= wiper[rx_instr.ch];
            end
        end else if (byte_done && byte_idx == BYTE_DATA) begin
            if (incdec_mode) begin
                if (rx_shift[STEP_UP_BIT]) begin
                    if (wiper[instr.ch] != TAP_MAX) begin
                        wiper[instr.ch] <= wiper[instr.ch] + 6'h01;
                    end
                end else if (wiper[instr.ch] != TAP_MIN) begin
                    wiper[instr.ch] <= wiper[instr.ch] - 6'h01;
                end
            end else if (instr.op == OP_WR_WIPER) begin
                wiper[instr.ch] <= rx_shift[WIPER_W-1:0];
            end else if (instr.op == OP_WR_SLOT) begin
                slot[cur_slot_idx] <= rx_shift[WIPER_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // tap switches, one decoder per channel
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
        dwss_tap_decode u_dec (
            .i_mclk(i_mclk),
            .i_reset_n(i_reset_n),
            .i_wiper(wiper[g]),
            .o_tap_select(o_tap_select[g])
        );
    end

endmodule : dwss_top

`default_nettype wire
